// ---- hw/tmc_defines.svh ----
// Constants for the transceiver mode and serial control block
//
// Functional notes
// - Three modes: normal, receive-only, battery standby, chosen by the control word.
// - Transmit only in normal; receive off in standby; autotiming off in normal.
// - A bus wake-up in standby drives the receive-data output low.
// - Any reset clears the control word, which gives battery standby.
// - Diagnosis bit 15 reports transceiver thermal shutdown.
// - Diagnosis bits 8 to 13 report six bus failure groups.
// - Single-line mode is entered only after a filter delay.
// - Differential mode returns only after a further delay once the failure clears.
// - Failure cases 3, 5, 6, 6a, 7 switch off termination and driver of that line.
// - In standby the low-line termination is switched to the battery supply.
// - Each transfer shifts 16 control bits in while diagnosis bits shift out.
// - Select rising loads the new control word and floats the serial output.
// - Internal delays count in cycles of 32 oscillator periods.
// - Each switch output except high switch one is on only while its control bit is set.
// - High switch one also follows the pulse-width input.
// - All high switches, autotiming included, go off on any reset.
// - Low switches go off on reset, watchdog reset or undercurrent watchdog-off.
// - At low current the watchdog stays active only if undercurrent function is off.
// - Control word goes LSB first; input bits are captured on the falling clock.
// - The serial output floats except while the select is low.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Register byte offsets
`define TMC_REG_CTRL      4'h0
`define TMC_REG_DIAG      4'h4
`define TMC_REG_STATUS    4'h8

// Control word fields
`define TMC_CW_WD_TRIG    0
`define TMC_CW_HS1        1
`define TMC_CW_HS2        2
`define TMC_CW_HS3        3
`define TMC_CW_HS3_AUTO   4
`define TMC_CW_LS1        5
`define TMC_CW_LS2        6
`define TMC_CW_SUPERV     7
`define TMC_CW_WD_UNDERI  8
`define TMC_CW_NOT_STBY   9
`define TMC_CW_TX_EN      10
`define TMC_CW_PWM_EN     11
`define TMC_CTRL_RESET    16'h0000

// Synchronised pin vector positions
`define TMC_PIN_W         18
`define TMC_P_SCLK        0
`define TMC_P_SEL_N       1
`define TMC_P_SIN         2
`define TMC_P_OSC         3
`define TMC_P_PWM         4
`define TMC_P_RST         5
`define TMC_P_WD_RST      6
`define TMC_P_ICC_LOW     7
`define TMC_P_WAKE        8
`define TMC_P_RX_BUS      9
`define TMC_P_THERM_CAN   10
`define TMC_P_THERM_SW    11
`define TMC_P_FAIL        12
`define TMC_PIN_IDLE      18'h00002

// Failure groups that disable a line (group n is diagnosis bit 8+n)
`define TMC_HIGH_OFF_MASK 6'h04
`define TMC_LOW_OFF_MASK  6'h38

// Timing: oscillator count per internal cycle, delays in internal cycles, frame bits
`define TMC_OSC_PER_CYC   5'h1f
`define TMC_FAIL_ON_CYC   4'h4
`define TMC_FAIL_OFF_CYC  4'h8
`define TMC_AUTO_ON_CYC   7'h02
`define TMC_SPI_BITS      5'h10

`endif

// ---- hw/tmc_pkg.sv ----
// Types for the transceiver mode and serial control block
package tmc_pkg;

  typedef enum logic [2:0] {
    TMC_STANDBY = 3'b001,
    TMC_RXONLY  = 3'b010,
    TMC_NORMAL  = 3'b100
  } tmc_mode_t;

  // All registered outputs apart from the AXI ports
  typedef struct packed {
    logic        serial_out;
    logic        serial_out_oe;
    logic        tx_enable;
    logic        rx_enable;
    logic        rxd;
    logic        high_line_termination;
    logic        low_line_termination;
    logic        low_term_to_battery;
    logic        high_driver_on;
    logic        low_driver_on;
    logic        high_switch_one;
    logic        high_switch_two;
    logic        high_switch_three;
    logic        low_switch_one;
    logic        low_switch_two;
    logic        watchdog_active;
    logic [5:0]  fail_active;
    tmc_mode_t   mode;
  } tmc_out_t;

  // AXI4-Lite slave state
  typedef struct packed {
    logic        aw_held;
    logic [3:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awready;
    logic        wready;
    logic        arready;
  } tmc_axi_t;

  // Whole module state
  typedef struct packed {
    logic [17:0]       s1;
    logic [17:0]       s2;
    logic [17:0]       s3;
    logic [17:0]       filt;
    logic [15:0]       sin;
    logic [15:0]       sout;
    logic [4:0]        bits;
    logic [15:0]       ctrl;
    logic [4:0]        osc_cnt;
    logic [6:0]        auto_cnt;
    logic [5:0][3:0]   flt_cnt;
    logic [5:0]        fail_act;
    logic              wake;
    tmc_axi_t          axi;
    tmc_out_t          o;
  } tmc_state_t;

endpackage

// ---- hw/tmc_spi_ctrl.sv ----
// Serial control word, mode decode, failure filter and switch logic
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_spi_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial port from the host
  input  wire logic        serial_clk,
  input  wire logic        serial_select_low,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Pins and analog status
  input  wire logic        timebase_resistor_pin,
  input  wire logic        pwm_in,
  input  wire logic        reset_event,
  input  wire logic        watchdog_reset,
  input  wire logic        icc_low,
  input  wire logic        bus_wake,
  input  wire logic        rx_bus_data,
  input  wire logic        thermal_can,
  input  wire logic        thermal_switch,
  input  wire logic [5:0]  bus_fail_raw,
  // Transceiver and switch controls
  output logic             tx_enable,
  output logic             rx_enable,
  output logic             rxd,
  output logic             high_line_termination,
  output logic             low_line_termination,
  output logic             low_term_to_battery,
  output logic             high_driver_on,
  output logic             low_driver_on,
  output logic             high_switch_one,
  output logic             high_switch_two,
  output logic             high_switch_three,
  output logic             low_switch_one,
  output logic             low_switch_two,
  output logic             watchdog_active,
  output logic [5:0]       fail_active,
  output logic [2:0]       mode
);

  tmc_pkg::tmc_state_t r;
  tmc_pkg::tmc_state_t next_r;
  logic [17:0]         pins;

  // Every serial port and status pin goes through the same three-stage filter; aresetn and the AXI ports do not
  assign pins = {bus_fail_raw, thermal_switch, thermal_can, rx_bus_data, bus_wake, icc_low,
                 watchdog_reset, reset_event, pwm_in, timebase_resistor_pin, serial_in,
                 serial_select_low, serial_clk};

  // Next-state logic for the whole block
  always_comb begin
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sel_fall;
    logic        sel_rise;
    logic        tick;
    logic        any_rst;
    logic        wd_off;
    logic        auto_on;
    logic        raw;
    logic [15:0] diag;
    logic [31:0] rd;
    logic [1:0]  rresp;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    sel_fall  = 1'b0;
    sel_rise  = 1'b0;
    tick      = 1'b0;
    any_rst   = 1'b0;
    wd_off    = 1'b0;
    auto_on   = 1'b0;
    raw       = 1'b0;
    diag      = 16'h0000;
    rd        = 32'h00000000;
    rresp     = 2'h0;
    next_r    = r;

    // A change counts once the second and third stages agree
    next_r.s1   = pins;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.filt = (r.s2 & r.s3) | (r.filt & (r.s2 | r.s3));

    sclk_rise = ~r.filt[`TMC_P_SCLK] & next_r.filt[`TMC_P_SCLK];
    sclk_fall = r.filt[`TMC_P_SCLK] & ~next_r.filt[`TMC_P_SCLK];
    sel_fall  = r.filt[`TMC_P_SEL_N] & ~next_r.filt[`TMC_P_SEL_N];
    sel_rise  = ~r.filt[`TMC_P_SEL_N] & next_r.filt[`TMC_P_SEL_N];

    // Internal cycle: one tick per 32 oscillator periods
    if (~r.filt[`TMC_P_OSC] & next_r.filt[`TMC_P_OSC]) begin
      if (r.osc_cnt == `TMC_OSC_PER_CYC) begin
        next_r.osc_cnt = 5'h00;
        tick           = 1'b1;
      end else begin
        next_r.osc_cnt = r.osc_cnt + 5'h01;
      end
    end

    // Failure filters; the on and off delays differ so short glitches never switch
    for (int i = 0; i < 6; i++) begin
      raw = next_r.filt[`TMC_P_FAIL + i];
      if (raw == r.fail_act[i]) begin
        next_r.flt_cnt[i] = 4'h0;
      end else if (tick) begin
        if ((r.flt_cnt[i] + 4'h1) >= (raw ? `TMC_FAIL_ON_CYC : `TMC_FAIL_OFF_CYC)) begin
          next_r.fail_act[i] = raw;
          next_r.flt_cnt[i]  = 4'h0;
        end else begin
          next_r.flt_cnt[i] = r.flt_cnt[i] + 4'h1;
        end
      end
    end

    // Diagnosis word, captured at the start of each frame
    diag = {r.filt[`TMC_P_THERM_CAN], r.filt[`TMC_P_THERM_SW], r.fail_act, 1'b0,
            r.o.low_switch_two, r.o.low_switch_one, 5'h00};

    // Serial shifter: capture on falling clock, LSB first; output moves on rising
    if (sel_fall) begin
      next_r.sout = diag;
      next_r.bits = 5'h00;
    end else if (~next_r.filt[`TMC_P_SEL_N]) begin
      if (sclk_fall) begin
        next_r.sin = {next_r.filt[`TMC_P_SIN], r.sin[15:1]};
        if (r.bits != `TMC_SPI_BITS) begin
          next_r.bits = r.bits + 5'h01;
        end
      end
      if (sclk_rise && r.bits != 5'h00) begin
        next_r.sout = {1'b0, r.sout[15:1]};
      end
    end

    // AXI write: address and data are taken in either order
    if (s_axi_awvalid && !r.axi.aw_held && !r.axi.bvalid) begin
      next_r.axi.aw_held = 1'b1;
      next_r.axi.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.axi.w_held && !r.axi.bvalid) begin
      next_r.axi.w_held = 1'b1;
      next_r.axi.wdata  = s_axi_wdata;
      next_r.axi.wstrb  = s_axi_wstrb;
    end
    if (r.axi.aw_held && r.axi.w_held) begin
      next_r.axi.aw_held = 1'b0;
      next_r.axi.w_held  = 1'b0;
      next_r.axi.bvalid  = 1'b1;
      next_r.axi.bresp   = 2'h0;
      if (r.axi.awaddr[3:2] == `TMC_REG_CTRL >> 2) begin
        if (r.axi.wstrb[0]) begin
          next_r.ctrl[7:0] = r.axi.wdata[7:0];
        end
        if (r.axi.wstrb[1]) begin
          next_r.ctrl[15:8] = r.axi.wdata[15:8];
        end
      end else if (r.axi.awaddr[3:2] != `TMC_REG_DIAG >> 2 &&
                   r.axi.awaddr[3:2] != `TMC_REG_STATUS >> 2) begin
        next_r.axi.bresp = 2'h2;
      end
    end else if (r.axi.bvalid && s_axi_bready) begin
      next_r.axi.bvalid = 1'b0;
    end

    // Select rising takes the shifted word; it wins over a bus write
    if (sel_rise) begin
      next_r.ctrl = r.sin;
    end

    // Any reset clears the word last of all, so nothing can survive it
    any_rst = next_r.filt[`TMC_P_RST] | next_r.filt[`TMC_P_WD_RST];
    if (any_rst) begin
      next_r.ctrl = `TMC_CTRL_RESET;
    end

    // Mode decode; all-zero word gives standby
    if (!next_r.ctrl[`TMC_CW_NOT_STBY]) begin
      next_r.o.mode = tmc_pkg::TMC_STANDBY;
    end else if (next_r.ctrl[`TMC_CW_TX_EN]) begin
      next_r.o.mode = tmc_pkg::TMC_NORMAL;
    end else begin
      next_r.o.mode = tmc_pkg::TMC_RXONLY;
    end

    next_r.o.tx_enable = (next_r.o.mode == tmc_pkg::TMC_NORMAL);
    next_r.o.rx_enable = (next_r.o.mode != tmc_pkg::TMC_STANDBY);

    // Wake flag: set in standby, cleared by leaving standby or by the bus reset, so clearing wins
    if (next_r.o.mode != tmc_pkg::TMC_STANDBY) begin
      next_r.wake = 1'b0;
    end else if (next_r.filt[`TMC_P_WAKE]) begin
      next_r.wake = 1'b1;
    end
    next_r.o.rxd = next_r.o.rx_enable ? next_r.filt[`TMC_P_RX_BUS] : ~next_r.wake;

    // Line handling for failures and standby
    next_r.o.fail_active           = next_r.fail_act;
    next_r.o.high_line_termination = ~|(next_r.fail_act & `TMC_HIGH_OFF_MASK);
    next_r.o.low_line_termination  = ~|(next_r.fail_act & `TMC_LOW_OFF_MASK);
    next_r.o.high_driver_on = next_r.o.tx_enable & next_r.o.high_line_termination;
    next_r.o.low_driver_on  = next_r.o.tx_enable & next_r.o.low_line_termination;
    next_r.o.low_term_to_battery = (next_r.o.mode == tmc_pkg::TMC_STANDBY);

    // Watchdog off only when low current meets the enabled undercurrent function
    wd_off = next_r.filt[`TMC_P_ICC_LOW] & next_r.ctrl[`TMC_CW_WD_UNDERI];
    next_r.o.watchdog_active = ~wd_off;

    // Autotiming of high switch three outside normal mode
    auto_on = next_r.ctrl[`TMC_CW_HS3] & next_r.ctrl[`TMC_CW_HS3_AUTO] &
              (next_r.o.mode != tmc_pkg::TMC_NORMAL) & ~any_rst;
    if (!auto_on) begin
      next_r.auto_cnt = 7'h00;
    end else if (tick) begin
      next_r.auto_cnt = r.auto_cnt + 7'h01; // wraps every 128 internal cycles
    end

    // Switch outputs; resets hold them off in the same cycle that the word clears
    next_r.o.high_switch_one = ~any_rst & (next_r.ctrl[`TMC_CW_HS1] |
      (next_r.ctrl[`TMC_CW_PWM_EN] & next_r.filt[`TMC_P_PWM]));
    next_r.o.high_switch_two = ~any_rst & next_r.ctrl[`TMC_CW_HS2];
    next_r.o.high_switch_three = auto_on ? (next_r.auto_cnt < `TMC_AUTO_ON_CYC)
                               : (~any_rst & next_r.ctrl[`TMC_CW_HS3]);
    next_r.o.low_switch_one = ~any_rst & ~wd_off & next_r.ctrl[`TMC_CW_LS1];
    next_r.o.low_switch_two = ~any_rst & ~wd_off & next_r.ctrl[`TMC_CW_LS2];

    // Serial output drives only while selected
    next_r.o.serial_out    = next_r.sout[0];
    next_r.o.serial_out_oe = ~next_r.filt[`TMC_P_SEL_N];

    // AXI read; one cycle from acceptance to data
    if (s_axi_arvalid && !r.axi.rvalid) begin
      unique case (s_axi_araddr[3:2])
        2'h0:    rd = {16'h0000, r.ctrl};
        2'h1:    rd = {16'h0000, diag};
        2'h2:    rd = {14'h0000, r.o.mode, r.o.fail_active, r.o.watchdog_active,
                       r.o.low_switch_two, r.o.low_switch_one, r.o.high_switch_three,
                       r.o.high_switch_two, r.o.high_switch_one, r.o.rx_enable,
                       r.o.tx_enable, r.wake};
        default: rresp = 2'h2;
      endcase
      next_r.axi.rvalid = 1'b1;
      next_r.axi.rdata  = rd;
      next_r.axi.rresp  = rresp;
    end else if (r.axi.rvalid && s_axi_rready) begin
      next_r.axi.rvalid = 1'b0;
    end

    // Readies are registered too, so no port is a gate away from a flip-flop
    next_r.axi.awready = ~next_r.axi.aw_held & ~next_r.axi.bvalid;
    next_r.axi.wready  = ~next_r.axi.w_held & ~next_r.axi.bvalid;
    next_r.axi.arready = ~next_r.axi.rvalid;
  end

  // State register; reset value puts the block in standby with all switches and drivers off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.s1     <= `TMC_PIN_IDLE;
      r.s2     <= `TMC_PIN_IDLE;
      r.s3     <= `TMC_PIN_IDLE;
      r.filt   <= `TMC_PIN_IDLE;
      r.ctrl   <= `TMC_CTRL_RESET;
      r.o.mode <= tmc_pkg::TMC_STANDBY;
      r.o.rxd  <= 1'b1;
      r.o.high_line_termination <= 1'b1;
      r.o.low_line_termination  <= 1'b1;
      r.o.low_term_to_battery   <= 1'b1;
      r.o.watchdog_active       <= 1'b1;
      r.axi.awready             <= 1'b1;
      r.axi.wready              <= 1'b1;
      r.axi.arready             <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Ports straight from the state register
  assign s_axi_awready = r.axi.awready;
  assign s_axi_wready  = r.axi.wready;
  assign s_axi_bvalid  = r.axi.bvalid;
  assign s_axi_bresp   = r.axi.bresp;
  assign s_axi_arready = r.axi.arready;
  assign s_axi_rvalid  = r.axi.rvalid;
  assign s_axi_rdata   = r.axi.rdata;
  assign s_axi_rresp   = r.axi.rresp;
  assign serial_out            = r.o.serial_out;
  assign serial_out_oe         = r.o.serial_out_oe;
  assign tx_enable             = r.o.tx_enable;
  assign rx_enable             = r.o.rx_enable;
  assign rxd                   = r.o.rxd;
  assign high_line_termination = r.o.high_line_termination;
  assign low_line_termination  = r.o.low_line_termination;
  assign low_term_to_battery   = r.o.low_term_to_battery;
  assign high_driver_on        = r.o.high_driver_on;
  assign low_driver_on         = r.o.low_driver_on;
  assign high_switch_one       = r.o.high_switch_one;
  assign high_switch_two       = r.o.high_switch_two;
  assign high_switch_three     = r.o.high_switch_three;
  assign low_switch_one        = r.o.low_switch_one;
  assign low_switch_two        = r.o.low_switch_two;
  assign watchdog_active       = r.o.watchdog_active;
  assign fail_active           = r.o.fail_active;
  assign mode                  = r.o.mode;

endmodule

// ---- dv/tmc_host_model.sv ----
// Host serial master model that drives frames on the control port
`timescale 1ns/1ps

module tmc_host_model (
  output logic      serial_clk,
  output logic      serial_select_low,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // Clock idles low and stands still between frames
  initial begin
    serial_clk = 1'b0;
    serial_select_low = 1'b1;
    serial_in = 1'b0;
  end

  // One bit per 160 ns; data moves mid low phase, well away from the falling edge
  task automatic xfer(input logic [15:0] cw, output logic [15:0] dg);
    serial_select_low <= 1'b0;
    serial_in <= cw[0];
    #160;
    for (int i = 0; i < 16; i++) begin
      serial_clk <= 1'b1;
      // A floating output reads as the inverse, so it can never pass as data
      #80 dg[i] = serial_out_oe ? serial_out : ~serial_out;
      serial_clk <= 1'b0;
      #40;
      if (i < 15) serial_in <= cw[i + 1];
      #40;
    end
    serial_select_low <= 1'b1;
    serial_in <= ~serial_in; // Released line must not look like a held bit
    #200;
  endtask
endmodule

// ---- dv/tmc_spi_ctrl_sva.sv ----
// Port checks for the serial control block
`timescale 1ns/1ps

module tmc_spi_ctrl_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       serial_select_low,
  input wire logic       serial_out_oe,
  input wire logic       reset_event,
  input wire logic       bus_wake,
  input wire logic [5:0] bus_fail_raw,
  input wire logic       tx_enable,
  input wire logic       rx_enable,
  input wire logic       rxd,
  input wire logic       high_line_termination,
  input wire logic       low_term_to_battery,
  input wire logic       high_driver_on,
  input wire logic       high_switch_one,
  input wire logic       high_switch_two,
  input wire logic       high_switch_three,
  input wire logic       low_switch_one,
  input wire logic       low_switch_two,
  input wire logic [5:0] fail_active,
  input wire logic [2:0] mode
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_normal: assert property (tx_enable |-> mode == 3'b100)
    else $error("transmit enabled outside normal mode");
  a_rst_standby: assert property (reset_event [*8] |-> mode == 3'b001 && !rx_enable)
    else $error("reset pin did not force standby");
  a_rst_switch: assert property (reset_event [*8] |->
    !(high_switch_one | high_switch_two | high_switch_three | low_switch_one | low_switch_two))
    else $error("switch on during reset");
  // Pins pass a synchroniser, so the enable lags the select by a few clocks
  a_oe_select: assert property ($rose(serial_out_oe) |-> !$past(serial_select_low, 2))
    else $error("serial output enabled without select");
  a_oe_release: assert property (serial_select_low [*8] |-> !serial_out_oe)
    else $error("serial output still driven after select high");
  a_fail_filter: assert property ($rose(fail_active[2]) |-> $past(bus_fail_raw[2], 6))
    else $error("failure flagged without a lasting fault");
  a_fail_hold: assert property ($fell(fail_active[3]) |-> !$past(bus_fail_raw[3], 6))
    else $error("failure cleared too soon");
  a_high_off: assert property (fail_active[2] && $past(fail_active[2]) |->
    !high_driver_on && !high_line_termination) else $error("faulty high line left on");
  a_standby_bat: assert property (mode == 3'b001 && $past(mode) == 3'b001 |->
    low_term_to_battery) else $error("low termination not on battery in standby");
  a_wake_rxd: assert property ((mode == 3'b001 && bus_wake) [*8] |-> !rxd)
    else $error("bus wake not shown on rxd");

  c_normal: cover property (tx_enable);
  c_frame: cover property ($rose(serial_out_oe));
  c_high_fail: cover property (fail_active[2] && !high_line_termination);
endmodule

bind tmc_spi_ctrl tmc_spi_ctrl_sva chk (.*);

// ---- dv/tmc_spi_ctrl_test.sv ----
// Self-checking bench for the serial control block
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_spi_ctrl_test;
  typedef struct packed {
    logic [15:0] cw;
    logic        pw;
    logic [2:0]  md;
    logic [7:0]  o;
  } tmc_row_t;
  // Bench drives and design outputs
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        timebase_resistor_pin = 1'b0, pwm_in = 1'b0, reset_event = 1'b0;
  logic        watchdog_reset = 1'b0, icc_low = 1'b0, bus_wake = 1'b0, rx_bus_data = 1'b0;
  logic        thermal_can = 1'b0, thermal_switch = 1'b0;
  logic [5:0]  bus_fail_raw = 6'h00, fail_active;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        serial_clk, serial_select_low, serial_in, serial_out, serial_out_oe;
  logic        tx_enable, rx_enable, rxd, high_line_termination, low_line_termination;
  logic        low_term_to_battery, high_driver_on, low_driver_on, watchdog_active;
  logic        high_switch_one, high_switch_two, high_switch_three;
  logic        low_switch_one, low_switch_two;
  logic [2:0]  mode;
  logic [15:0] dg;
  int          bad_count = 0, checked = 0;
  // Outputs: {tx, rx, hs1, hs2, hs3, ls1, ls2, battery termination}
  tmc_row_t    rows [12] = '{
    '{16'h0000, 1'b0, 3'b001, 8'h01}, '{16'h0200, 1'b0, 3'b010, 8'h40},
    '{16'h0600, 1'b0, 3'b100, 8'hc0}, '{16'h0400, 1'b0, 3'b001, 8'h01},
    '{16'h0602, 1'b0, 3'b100, 8'he0}, '{16'h0604, 1'b0, 3'b100, 8'hd0},
    '{16'h0608, 1'b0, 3'b100, 8'hc8}, '{16'h0660, 1'b0, 3'b100, 8'hc6},
    '{16'h0800, 1'b1, 3'b001, 8'h21}, '{16'h0800, 1'b0, 3'b001, 8'h01},
    '{16'h0002, 1'b0, 3'b001, 8'h21}, '{16'h0218, 1'b0, 3'b010, 8'h48}};

  tmc_spi_ctrl uut (.*);
  tmc_host_model host (.*);

  // 100 MHz clock; oscillator of 40 ns gives a 128-clock internal cycle
  always #5 aclk = ~aclk;
  always #20 timebase_resistor_pin = ~timebase_resistor_pin;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    bad_count++;
    final_report;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together; each drops once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1) hang("bvalid");
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1) hang("rvalid");
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Control write, then time for the pin synchronisers to settle
  task automatic put(input logic [15:0] cw);
    axi_wr(`TMC_REG_CTRL, {16'h0, cw}, r);
    tick(8);
  endtask

  task automatic outs(input logic [7:0] e);
    chk("outputs", e, {tx_enable, rx_enable, high_switch_one, high_switch_two,
      high_switch_three, low_switch_one, low_switch_two, low_term_to_battery});
  endtask

  task automatic wait_fa(input logic [5:0] w);
    for (int n = 0; n < 800 && fail_active !== w; n++) tick(1);
    if (fail_active !== w) hang("fail_active");
    checked++;
  endtask

  // Main sequence
  initial begin
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    chk("mode", 3'b001, mode);
    outs(8'h01);
    chk("oe", 1'b0, serial_out_oe);
    foreach (rows[i]) begin
      pwm_in <= rows[i].pw;
      put(rows[i].cw);
      chk("mode", rows[i].md, mode);
      outs(rows[i].o);
      axi_rd(`TMC_REG_CTRL, d, r);
      chk("ctrl", rows[i].cw, d);
    end
    $display("test rows done");
    // Autotiming must let high switch three go after its short on-time
    put(16'h0018);
    tick(400);
    outs(8'h01);
    // Reset pin, watchdog reset and bus reset in turn
    for (int k = 0; k < 3; k++) begin
      put(16'h066e);
      reset_event <= (k == 0);
      watchdog_reset <= (k == 1);
      aresetn <= (k != 2);
      tick(10);
      outs(8'h01);
      reset_event <= 1'b0;
      watchdog_reset <= 1'b0;
      aresetn <= 1'b1;
      axi_rd(`TMC_REG_CTRL, d, r);
      chk("ctrl", 32'h0, d);
    end
    $display("test resets done");
    put(16'h0160);
    icc_low <= 1'b1;
    tick(8);
    chk("ls wd", 3'b000, {low_switch_one, low_switch_two, watchdog_active});
    icc_low <= 1'b0;
    tick(8);
    chk("ls wd", 3'b111, {low_switch_one, low_switch_two, watchdog_active});
    put(16'h0000);
    bus_wake <= 1'b1;
    tick(10);
    chk("rxd", 1'b0, rxd);
    bus_wake <= 1'b0;
    rx_bus_data <= 1'b1;
    put(16'h0200);
    chk("rxd", 1'b1, rxd);
    $display("test wake done");
    axi_wr(4'hc, 32'h0, r);
    chk("bresp", 2'b10, r);
    axi_rd(4'hc, d, r);
    chk("rresp", 2'b10, r);
    chk("rdata", 32'h0, d);
    // Each failure group: filter in, report, disable, filter out
    thermal_can <= 1'b1;
    put(16'h0600);
    for (int g = 0; g < 6; g++) begin
      bus_fail_raw <= 6'h01 << g;
      tick(300);
      chk("early", 6'h00, fail_active);
      wait_fa(6'h01 << g);
      chk("term", {g != 2, g < 3, g != 2, g < 3},
        {high_line_termination, low_line_termination, high_driver_on, low_driver_on});
      host.xfer(16'h0600, dg);
      chk("diag", 16'h8000 | (16'h0100 << g), dg);
      chk("oe", 1'b0, serial_out_oe);
      bus_fail_raw <= 6'h00;
      tick(600);
      chk("hold", 6'h01 << g, fail_active);
      wait_fa(6'h00);
    end
    $display("test failures done");
    host.xfer(16'h0622, dg);
    chk("diag", 16'h8000, dg);
    tick(8);
    chk("mode", 3'b100, mode);
    outs(8'he4);
    host.xfer(16'h0000, dg);
    chk("diag", 16'h8020, dg);
    tick(8);
    outs(8'h01);
    $display("test serial done");
    final_report;
  end
endmodule
